/* logic/par_pkg.sv */
/*
 Package for the negotiation and test register group.
 Holds register indices, bit positions, reset values and timing counts.
 Assumes a 125 MHz device clock.
*/
`default_nettype none
package par_pkg;
    // ==========================================
    // Register indices (management address space)
    localparam logic [4:0] PAR_IDX_PARTNER_ABILITY = 5'h05;
    localparam logic [4:0] PAR_IDX_EXPANSION = 5'h06;
    localparam logic [4:0] PAR_IDX_SETUP = 5'h10;
    localparam logic [4:0] PAR_IDX_LOOPBACK = 5'h11;
    localparam logic [4:0] PAR_IDX_RX_COUNT = 5'h12;
    localparam logic [4:0] PAR_IDX_PARAM_LO = 5'h14;
    localparam logic [4:0] PAR_IDX_PARAM_HI = 5'h18;
    // ==========================================
    // Expansion status bits
    localparam int PAR_EXP_MULTI_FAULT = 4;
    localparam int PAR_EXP_PARTNER_NP = 3;
    localparam int PAR_EXP_LOCAL_NP = 2;
    localparam int PAR_EXP_PAGE_RX = 1;
    localparam int PAR_EXP_PARTNER_AN = 0;
    localparam int PAR_PARTNER_NP_BIT = 15;
    // ==========================================
    // Setup register bits
    localparam int PAR_SET_LED_PULSE = 11;
    localparam int PAR_SET_SPEEDUP = 10;
    localparam int PAR_SET_AN_LOOP = 9;
    localparam int PAR_SET_VIS_ABD = 2;
    localparam int PAR_SET_VIS_PDF = 1;
    localparam int PAR_SET_VIS_LSC = 0;
    localparam logic [15:0] PAR_SET_RW_MASK = 16'h0e00;
    // ==========================================
    // Loopback / bypass / error mask register
    localparam logic [15:0] PAR_LB_RW_MASK = 16'hfb9f;
    localparam logic [15:0] PAR_LB_RESET = 16'h0080;
    localparam logic [15:0] PAR_ZERO = 16'h0000;
    localparam logic [1:0] PAR_LOOP_NORMAL = 2'h0;
    localparam logic [1:0] PAR_LOOP_PHY = 2'h1;
    localparam logic [1:0] PAR_LOOP_PAIR = 2'h2;
    // ==========================================
    // Packet time-out
    localparam int PAR_CLOCK_KHZ = 125000;
    localparam int PAR_PKT_TIMEOUT_MS = 722;
    localparam int PAR_PKT_TIMEOUT_CYCLES = PAR_PKT_TIMEOUT_MS * PAR_CLOCK_KHZ;

    typedef struct packed {
        logic repeater_mode_enable;
        logic coder_bypass;
        logic scrambler_bypass;
        logic link_down_power_saving;
        logic analog_power_down;
        logic [1:0] loopback_select;
        logic force_link_100;
        logic code_error_report_enable;
        logic premature_end_report_enable;
        logic link_error_report_enable;
        logic packet_timeout_report_enable;
        logic parameter_access_enable;
    } par_ctrl_t;

    typedef struct packed {
        logic phy_loopback;
        logic pair_loopback;
        logic speedup;
        logic an_loopback;
    } par_mode_t;
endpackage : par_pkg
`default_nettype wire

/* logic/par_sticky.sv */
/*
 One sticky flag: set by an event, cleared by a request.
 Assumes both inputs are on the device clock.
*/
`default_nettype none
module par_sticky
(
    input wire logic clock,
    input wire logic rst,
    input wire logic set,
    input wire logic clear,
    output logic flag
);
    // ==========================================
    // Set beats a clear in the same cycle
    always_ff @(posedge clock)
    begin
        if (rst)
            flag <= 1'b0;
        else if (set)
            flag <= 1'b1;
        else if (clear)
            flag <= 1'b0;
    end
endmodule : par_sticky
`default_nettype wire

/* logic/par_timeout.sv */
/*
 Packet time-out counter: pulses once when a packet runs too long.
 Assumes the packet level is on the device clock.
*/
`default_nettype none
module par_timeout
#(
    parameter int LIMIT = 90250000
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic in_packet,
    output logic expired
);
    logic [31:0] count_reg;
    logic hit;
    assign hit = in_packet && (count_reg == 32'(LIMIT - 1));
    // ==========================================
    // One pulse per over-long packet; counter parks after it
    always_ff @(posedge clock)
    begin
        if (rst || !in_packet)
            count_reg <= 32'h0000_0000;
        else if (count_reg != 32'(LIMIT))
            count_reg <= count_reg + 32'h0000_0001;
    end
    assign expired = hit;
endmodule : par_timeout
`default_nettype wire

/* logic/par_regs.sv */
/*
 Negotiation expansion, setup, loopback/error-mask and receive counter registers.
 Assumes a management frame engine presents decoded register reads and writes
 on the device clock; negotiation and datapath events arrive on the same clock.
*/
`default_nettype none
// Behaviour
// (RULE_01) Multiple fault latched, cleared on read
// (RULE_02) Bit 3 mirrors partner next-page bit
// (RULE_03) Local next-page bit always zero
// (RULE_04) Page-arrived set on accepted page
// (RULE_05) Page-arrived cleared: link loss, reset, read
// (RULE_06) Partner-negotiation-capable only once known
// (RULE_07) Expansion bits 15 to 5 read zero
// (RULE_08) LED select routes link pulses to pin
// (RULE_09) Speed-up bit shortens negotiation timers
// (RULE_10) Loopback bit loops negotiation function
// (RULE_11) Three sticky state-visited flags
// (RULE_12) Repeater mode bit, default zero
// (RULE_13) Coder and scrambler bypass bits
// (RULE_14) Link-down power saving enable
// (RULE_15) Analog power down bit
// (RULE_16) Loopback select decode, reset normal
// (RULE_17) Forced 100M link bit, resets one
// (RULE_18) Enabled code, premature, link errors reported
// (RULE_19) Enabled 722 ms packet time-out reported
// (RULE_20) Parameter registers gated by access bit
// (RULE_21) 16-bit counter counts qualifying packets
// (RULE_22) Controller reaches registers over management link
// (RULE_23) Writes to reserved and status ignored
module par_regs
import par_pkg::*;
#(
    parameter int PKT_TIMEOUT = par_pkg::PAR_PKT_TIMEOUT_CYCLES
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic reg_read,
    input wire logic reg_write,
    input wire logic [4:0] reg_index,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic param_access_grant,
    input wire logic [15:0] partner_ability,
    input wire logic multi_fault_event,
    input wire logic page_accepted,
    input wire logic link_lost,
    input wire logic partner_an_known,
    input wire logic partner_an_compliant,
    input wire logic an_restart,
    input wire logic enter_ability_detect,
    input wire logic enter_parallel_fault,
    input wire logic enter_link_check,
    input wire logic link_pulse,
    input wire logic fourth_indicator_pin_default,
    output logic fourth_indicator_pin,
    input wire logic rx_code_error,
    input wire logic rx_premature_end,
    input wire logic rx_link_error,
    input wire logic rx_in_packet,
    input wire logic rx_packet_done,
    output logic rx_error_report,
    output var par_ctrl_t ctrl,
    output var par_mode_t mode
);
    import par_pkg::*;

    // ==========================================
    // Decode
    logic rd_exp, wr_setup, wr_lb, wr_cnt, rd_partner;
    logic in_param_range;
    assign rd_exp = reg_read && (reg_index == PAR_IDX_EXPANSION);
    assign rd_partner = reg_read && (reg_index == PAR_IDX_PARTNER_ABILITY);
    assign wr_setup = reg_write && (reg_index == PAR_IDX_SETUP);
    assign wr_lb = reg_write && (reg_index == PAR_IDX_LOOPBACK);
    assign wr_cnt = reg_write && (reg_index == PAR_IDX_RX_COUNT);
    assign in_param_range = (reg_index >= PAR_IDX_PARAM_LO) && (reg_index <= PAR_IDX_PARAM_HI);

    // ==========================================
    // Registers
    logic [15:0] setup_reg, lb_reg, count_reg;
    logic partner_an_reg;
    logic multi_fault_latch, page_rx_flag;
    logic visited_ability_detect, visited_parallel_fault, visited_link_check;

    par_sticky u_mlf (.clock(clock), .rst(rst), .set(multi_fault_event),
        .clear(rd_exp), .flag(multi_fault_latch)); // RULE_01
    par_sticky u_page (.clock(clock), .rst(rst), .set(page_accepted),
        .clear(link_lost || rd_partner), .flag(page_rx_flag)); // RULE_04 RULE_05
    par_sticky u_abd (.clock(clock), .rst(rst), .set(enter_ability_detect),
        .clear(1'b0), .flag(visited_ability_detect)); // RULE_11
    par_sticky u_pdf (.clock(clock), .rst(rst), .set(enter_parallel_fault),
        .clear(1'b0), .flag(visited_parallel_fault)); // RULE_11
    par_sticky u_lsc (.clock(clock), .rst(rst), .set(enter_link_check),
        .clear(1'b0), .flag(visited_link_check)); // RULE_11

    // Partner capability: known only after exchange, zero on restart
    always_ff @(posedge clock)
    begin
        if (rst || an_restart)
            partner_an_reg <= 1'b0;
        else if (partner_an_known)
            partner_an_reg <= partner_an_compliant; // RULE_06
    end

    // Only writable bits take data; the rest keep reading as before
    logic [15:0] setup_next, lb_next;
    assign setup_next = reg_wdata & PAR_SET_RW_MASK; // RULE_23
    assign lb_next = reg_wdata & PAR_LB_RW_MASK; // RULE_23

    always_ff @(posedge clock)
    begin
        if (rst)
            setup_reg <= PAR_ZERO;
        else if (wr_setup)
            setup_reg <= setup_next;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            lb_reg <= PAR_LB_RESET; // RULE_12 RULE_16 RULE_17
        else if (wr_lb)
            lb_reg <= lb_next;
    end

    // Counter: a software write wins over a packet in the same cycle
    logic [15:0] count_next;
    assign count_next = count_reg + 16'h0001;
    always_ff @(posedge clock)
    begin
        if (rst)
            count_reg <= PAR_ZERO;
        else if (wr_cnt)
            count_reg <= reg_wdata;
        else if (rx_packet_done)
            count_reg <= count_next; // RULE_21
    end

    // ==========================================
    // Control outputs
    assign ctrl.repeater_mode_enable = lb_reg[15]; // RULE_12
    assign ctrl.coder_bypass = lb_reg[14]; // RULE_13
    assign ctrl.scrambler_bypass = lb_reg[13]; // RULE_13
    assign ctrl.link_down_power_saving = lb_reg[12]; // RULE_14
    assign ctrl.analog_power_down = lb_reg[11]; // RULE_15
    assign ctrl.loopback_select = lb_reg[9:8]; // RULE_16
    assign ctrl.force_link_100 = lb_reg[7]; // RULE_17
    assign ctrl.code_error_report_enable = lb_reg[4];
    assign ctrl.premature_end_report_enable = lb_reg[3];
    assign ctrl.link_error_report_enable = lb_reg[2];
    assign ctrl.packet_timeout_report_enable = lb_reg[1];
    assign ctrl.parameter_access_enable = lb_reg[0];

    assign mode.phy_loopback = (lb_reg[9:8] == PAR_LOOP_PHY); // RULE_16
    assign mode.pair_loopback = (lb_reg[9:8] == PAR_LOOP_PAIR); // RULE_16
    assign mode.speedup = setup_reg[PAR_SET_SPEEDUP]; // RULE_09
    assign mode.an_loopback = setup_reg[PAR_SET_AN_LOOP]; // RULE_10

    assign fourth_indicator_pin = setup_reg[PAR_SET_LED_PULSE] ? link_pulse : fourth_indicator_pin_default; // RULE_08

    // Parameter window opens only with the access bit set
    assign param_access_grant = (reg_read || reg_write) && in_param_range && lb_reg[0]; // RULE_20

    // ==========================================
    // Error reporting
    logic pkt_expired;
    par_timeout #(.LIMIT(PKT_TIMEOUT)) u_timeout (.clock(clock), .rst(rst),
        .in_packet(rx_in_packet), .expired(pkt_expired));
    logic err_any;
    assign err_any = (lb_reg[4] && rx_code_error) || (lb_reg[3] && rx_premature_end)
        || (lb_reg[2] && rx_link_error); // RULE_18
    always_ff @(posedge clock)
    begin
        if (rst)
            rx_error_report <= 1'b0;
        else
            rx_error_report <= err_any || (lb_reg[1] && pkt_expired); // RULE_19
    end

    // ==========================================
    // Read mux
    logic [15:0] exp_value, setup_value, rd_value;
    assign exp_value = {11'h000, multi_fault_latch, partner_ability[PAR_PARTNER_NP_BIT],
        1'b0, page_rx_flag, partner_an_reg}; // RULE_02 RULE_03 RULE_07
    assign setup_value = setup_reg | {13'h0000, visited_ability_detect,
        visited_parallel_fault, visited_link_check}; // RULE_11
    assign rd_value = (reg_index == PAR_IDX_EXPANSION) ? exp_value :
        (reg_index == PAR_IDX_SETUP) ? setup_value :
        (reg_index == PAR_IDX_LOOPBACK) ? lb_reg :
        (reg_index == PAR_IDX_RX_COUNT) ? count_reg : PAR_ZERO;
    // Read data is captured with the read, before the clear lands
    always_ff @(posedge clock)
    begin
        if (rst)
            reg_rdata <= PAR_ZERO;
        else if (reg_read)
            reg_rdata <= rd_value; // RULE_22
    end

    // ==========================================
    // Checks
    a_fault_clear: assert property (@(posedge clock) disable iff (rst)
        rd_exp && !multi_fault_event |=> !multi_fault_latch) // RULE_01
        else $error("fault flag not cleared by read");
    a_fault_set: assert property (@(posedge clock) disable iff (rst)
        multi_fault_event |=> multi_fault_latch) // RULE_01
        else $error("fault flag not set");
    a_page_clear: assert property (@(posedge clock) disable iff (rst)
        (link_lost || rd_partner) && !page_accepted |=> !page_rx_flag) // RULE_05
        else $error("page flag not cleared");
    a_page_set: assert property (@(posedge clock) disable iff (rst)
        page_accepted |=> page_rx_flag) // RULE_04
        else $error("page flag not set");
    a_exp_upper: assert property (@(posedge clock) disable iff (rst)
        $past(rd_exp) |-> reg_rdata[15:5] == 11'h000 && reg_rdata[2] == 1'b0) // RULE_07
        else $error("expansion reserved bits nonzero");
    a_lb_reset: assert property (@(posedge clock)
        $past(rst) |-> lb_reg == PAR_LB_RESET) // RULE_17
        else $error("loopback reset value wrong");
    a_param_gate: assert property (@(posedge clock) disable iff (rst)
        param_access_grant |-> ctrl.parameter_access_enable) // RULE_20
        else $error("parameter access without enable");
    a_count_step: assert property (@(posedge clock) disable iff (rst)
        rx_packet_done && !wr_cnt |=> count_reg == $past(count_reg) + 16'h0001) // RULE_21
        else $error("counter did not step");
    a_led_route: assert property (@(posedge clock) disable iff (rst)
        setup_reg[PAR_SET_LED_PULSE] |-> fourth_indicator_pin == link_pulse) // RULE_08
        else $error("led not routed");
    a_err_report: assert property (@(posedge clock) disable iff (rst)
        ctrl.code_error_report_enable && rx_code_error |=> rx_error_report) // RULE_18
        else $error("code error not reported");
endmodule : par_regs
`default_nettype wire

/* verification/par_mgmt_model.sv */
/*
 Management controller model: issues decoded register reads and writes.
 Assumes the device clock and a bench that calls its tasks in turn.
*/
`default_nettype none
module par_mgmt_model
(
    input wire logic clock,
    output logic reg_read,
    output logic reg_write,
    output logic [4:0] reg_index,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================
    // Idle state
    initial
    begin
        reg_read = 1'b0;
        reg_write = 1'b0;
        reg_index = 5'h00;
        reg_wdata = 16'h0000;
    end
    // ==========================================
    // One-cycle access pulses
    task automatic wr(input logic [4:0] idx, input logic [15:0] data);
        @(posedge clock);
        #1;
        reg_write = 1'b1;
        reg_index = idx;
        reg_wdata = data;
        @(posedge clock);
        #1;
        reg_write = 1'b0;
        // Stale data inverted so a late sample cannot pass
        reg_wdata = ~data;
    endtask : wr
    task automatic rd(input logic [4:0] idx, output logic [15:0] data);
        @(posedge clock);
        #1;
        reg_read = 1'b1;
        reg_index = idx;
        @(posedge clock);
        #1;
        reg_read = 1'b0;
        data = reg_rdata;
    endtask : rd
endmodule : par_mgmt_model
`default_nettype wire

/* verification/testbench.sv */
/*
 Self-checking bench for the negotiation and test register group.
 Assumes the management model file is compiled first.
*/
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import par_pkg::*;
    logic clock = 1'b0, rst = 1'b1, reg_read, reg_write, grant, pin, report;
    logic link_pulse = 1'b0, fourth_indicator_pin_default = 1'b0, compliant = 1'b0, in_packet = 1'b0;
    logic [4:0] reg_index;
    logic [15:0] reg_wdata, reg_rdata, d, ability = 16'h0000;
    logic [11:0] ev = 12'h000;
    par_ctrl_t ctrl;
    par_mode_t mode;
    int errors = 0, checks_done = 0;
    always #4 clock = ~clock;
    // ==========================================
    // Units under test
    par_regs #(.PKT_TIMEOUT(20)) u_par_regs (.clock(clock), .rst(rst), .reg_read(reg_read),
        .reg_write(reg_write), .reg_index(reg_index), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .param_access_grant(grant), .partner_ability(ability),
        .multi_fault_event(ev[0]), .page_accepted(ev[1]), .link_lost(ev[2]),
        .partner_an_known(ev[3]), .partner_an_compliant(compliant), .an_restart(ev[4]),
        .enter_ability_detect(ev[5]), .enter_parallel_fault(ev[6]),
        .enter_link_check(ev[7]), .link_pulse(link_pulse), .fourth_indicator_pin_default(fourth_indicator_pin_default),
        .fourth_indicator_pin(pin), .rx_code_error(ev[8]), .rx_premature_end(ev[9]),
        .rx_link_error(ev[10]), .rx_in_packet(in_packet), .rx_packet_done(ev[11]),
        .rx_error_report(report), .ctrl(ctrl), .mode(mode));
    par_mgmt_model u_par_mgmt_model (.clock(clock), .reg_read(reg_read),
        .reg_write(reg_write), .reg_index(reg_index), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));
    // ==========================================
    // Shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            errors++;
        end
    endtask : chk
    task automatic rc(input logic [4:0] idx, input logic [15:0] exp);
        u_par_mgmt_model.rd(idx, d);
        chk(d, exp);
    endtask : rc
    task automatic wr(input logic [4:0] idx, input logic [15:0] data);
        u_par_mgmt_model.wr(idx, data);
    endtask : wr
    task automatic pulse(input int k);
        @(posedge clock);
        #1;
        ev[k] = 1'b1;
        @(posedge clock);
        #1;
        ev[k] = 1'b0;
    endtask : pulse
    // Bounded watch for the error report pulse
    task automatic watch(input int n, input logic exp);
        logic hit;
        hit = report;
        repeat (n)
        begin
            @(posedge clock);
            #1;
            hit = hit | report;
        end
        chk({15'h0000, hit}, {15'h0000, exp});
    endtask : watch
    task automatic grant_probe(input logic [4:0] idx, input logic exp);
        logic g;
        fork
            u_par_mgmt_model.rd(idx, d);
            begin
                @(posedge clock);
                #2;
                g = grant;
            end
        join
        chk({15'h0000, g}, {15'h0000, exp});
    endtask : grant_probe
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    // ==========================================
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clock);
        #1;
        rst = 1'b0;
        rc(5'h06, 16'h0000);
        rc(5'h10, 16'h0000);
        rc(5'h11, 16'h0080);
        rc(5'h12, 16'h0000);
        chk({3'h0, ctrl}, 16'h0020);
        chk({12'h000, mode}, 16'h0000);
        $display("reset values done");
        wr(5'h10, 16'hffff);
        rc(5'h10, 16'h0e00);
        wr(5'h11, 16'hffff);
        rc(5'h11, 16'hfb9f);
        chk({3'h0, ctrl}, 16'h1fff);
        chk({3'h0, ctrl}, 16'h1fff);
        chk({3'h0, ctrl}, 16'h1fff);
        wr(5'h06, 16'hffff);
        rc(5'h06, 16'h0000);
        for (int i = 0; i < 3; i++)
        begin
            wr(5'h11, {6'h00, i[1:0], 8'h00});
            wr(5'h10, (i == 1) ? 16'h0400 : (i == 2) ? 16'h0200 : 16'h0000);
            chk({12'h000, mode}, {12'h000, i == 1, i == 2, i == 1, i == 2});
            chk({12'h000, mode}, {12'h000, i == 1, i == 2, i == 1, i == 2});
            chk({12'h000, mode}, {12'h000, i == 1, i == 2, i == 1, i == 2});
        end
        wr(5'h10, 16'h0800);
        link_pulse = 1'b1;
        #1;
        chk({15'h0000, pin}, 16'h0001);
        wr(5'h10, 16'h0000);
        chk({15'h0000, pin}, 16'h0000);
        $display("control bits done");
        pulse(0);
        rc(5'h06, 16'h0010);
        rc(5'h06, 16'h0000);
        ability = 16'h8000;
        rc(5'h06, 16'h0008);
        pulse(1);
        rc(5'h06, 16'h000a);
        rc(5'h05, 16'h0000);
        rc(5'h06, 16'h0008);
        pulse(1);
        pulse(2);
        rc(5'h06, 16'h0008);
        compliant = 1'b0;
        pulse(3);
        rc(5'h06, 16'h0008);
        compliant = 1'b1;
        pulse(3);
        rc(5'h06, 16'h0009);
        pulse(4);
        rc(5'h06, 16'h0008);
        ability = 16'h0000;
        pulse(5);
        rc(5'h10, 16'h0004);
        pulse(6);
        rc(5'h10, 16'h0006);
        pulse(7);
        wr(5'h10, 16'h0000);
        rc(5'h10, 16'h0007);
        $display("status flags done");
        for (int k = 0; k < 3; k++)
            for (int en = 0; en < 2; en++)
            begin
                wr(5'h11, (en == 1) ? (16'h0010 >> k) : 16'h0000);
                pulse(8 + k);
                watch(4, en == 1);
            end
        wr(5'h11, 16'h0002);
        in_packet = 1'b1;
        watch(10, 1'b0);
        watch(20, 1'b1);
        in_packet = 1'b0;
        wr(5'h11, 16'h0000);
        in_packet = 1'b1;
        watch(30, 1'b0);
        in_packet = 1'b0;
        $display("error reports done");
        repeat (3) pulse(11);
        rc(5'h12, 16'h0003);
        wr(5'h12, 16'hffff);
        pulse(11);
        rc(5'h12, 16'h0000);
        grant_probe(5'h14, 1'b0);
        wr(5'h11, 16'h0001);
        grant_probe(5'h14, 1'b1);
        grant_probe(5'h18, 1'b1);
        grant_probe(5'h13, 1'b0);
        grant_probe(5'h19, 1'b0);
        rc(5'h19, 16'h0000);
        $display("counter and access done");
        summarize();
    end
endmodule : testbench
`default_nettype wire
